// ==== include/sdcd_map.svh ====
/*
  constants of the memory command decoder: widths, burst lengths, timing counts.
  assumes inclusion by bare name from design files.
*/
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH
`define SDCD_BANKS        8
`define SDCD_BA_W         3
`define SDCD_ADDR_W       16
`define SDCD_AP_POS       10
`define SDCD_BC_POS       12
`define SDCD_MR_OTF_POS   0
`define SDCD_MR_CHOP_POS  1
`define SDCD_BEATS_EIGHT  4'h8
`define SDCD_BEATS_FOUR   4'h4
`define SDCD_CLK_NS       40
`define SDCD_BURST_NS     160
`define SDCD_BURST_CYC    ((`SDCD_BURST_NS + `SDCD_CLK_NS - 1) / `SDCD_CLK_NS)
`endif

// ==== include/sdcd_pkg.sv ====
/*
  types of the memory command decoder.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sdcd_pkg;
  typedef enum logic [3:0] {
    SDCD_CMD_NONE, SDCD_CMD_MRS, SDCD_CMD_REF, SDCD_CMD_SRE, SDCD_CMD_SRX,
    SDCD_CMD_PRE, SDCD_CMD_ALL_BANK_CLOSE, SDCD_CMD_ACT, SDCD_CMD_WR, SDCD_CMD_RD,
    SDCD_CMD_ZQL, SDCD_CMD_ZQS, SDCD_CMD_PDE, SDCD_CMD_PDX, SDCD_CMD_ILL
  } sdcd_cmd_t;
  typedef enum logic [1:0] {
    SDCD_ST_RUN, SDCD_ST_PDN, SDCD_ST_SREF
  } sdcd_state_t;
endpackage

// ==== include/sdcd_pins_if.sv ====
/*
  synchronised command pins passed from the top to the decoder core.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdcd_pins_if;
  logic       cs_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic       cke;
  logic       cke_prev;
  logic [2:0] ba;
  logic       ap;
  logic       bc;
  modport src (output cs_n, ras_n, cas_n, we_n, cke, cke_prev, ba, ap, bc);
  modport dst (input cs_n, ras_n, cas_n, we_n, cke, cke_prev, ba, ap, bc);
endinterface
`default_nettype wire

// ==== core/sdcd_decode.sv ====
/*
  combinational command classification from one edge's sampled pins plus the previous edge's clock enable.
  assumes pins were sampled on the rising edge by the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcd_decode (
  sdcd_pins_if.dst          pins,
  output var sdcd_pkg::sdcd_cmd_t cmd_out
);
  logic [3:0] strobes;
  always_comb begin
    strobes = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    cmd_out = sdcd_pkg::SDCD_CMD_ILL;
    if (pins.cke_prev && pins.cke) begin
      if (pins.cs_n) cmd_out = sdcd_pkg::SDCD_CMD_NONE;
      else if (strobes == 4'h0) cmd_out = sdcd_pkg::SDCD_CMD_MRS;
      else if (strobes == 4'h1) cmd_out = sdcd_pkg::SDCD_CMD_REF;
      else if (strobes == 4'h2) cmd_out = pins.ap ? sdcd_pkg::SDCD_CMD_ALL_BANK_CLOSE
                                                  : sdcd_pkg::SDCD_CMD_PRE;
      else if (strobes == 4'h3) cmd_out = sdcd_pkg::SDCD_CMD_ACT;
      else if (strobes == 4'h4) cmd_out = sdcd_pkg::SDCD_CMD_WR;
      else if (strobes == 4'h5) cmd_out = sdcd_pkg::SDCD_CMD_RD;
      else if (strobes == 4'h6) cmd_out = pins.ap ? sdcd_pkg::SDCD_CMD_ZQL
                                                  : sdcd_pkg::SDCD_CMD_ZQS;
      else if (strobes == 4'h7) cmd_out = sdcd_pkg::SDCD_CMD_NONE;
    end else if (pins.cke_prev && !pins.cke) begin
      if (pins.cs_n || strobes == 4'h7) cmd_out = sdcd_pkg::SDCD_CMD_PDE;
      else if (strobes == 4'h1) cmd_out = sdcd_pkg::SDCD_CMD_SRE;
    end else if (!pins.cke_prev && pins.cke) begin
      if (pins.cs_n || strobes == 4'h7) cmd_out = sdcd_pkg::SDCD_CMD_PDX;
    end else begin
      cmd_out = sdcd_pkg::SDCD_CMD_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== core/sdcd_top.sv ====
/*
  command and clock-enable decoder of a double-data-rate memory device.
  assumes pins from the controller are asynchronous to ref_clk_in and are
  synchronised here; rst_n_in is the device reset pin.
*/
// Notes on behaviour
// - commands decode only from strobes, clock enable and autoclose bit sampled at rising edge
// - all strobes low, clock enable high: bank address picks mode register, address opcode
// - activate opens row; precharge closes one bank or all when autoclose bit high
// - read/write; autoclose bit adds precharge; chop bit picks length if enabled
// - a started burst always completes; no later command cuts it
// - calibration command: long when autoclose bit high, short otherwise; first long is initial
// - no-operation registers nothing and leaves running operations alone
// - deselect ignores all inputs but clock enable and acts like no-operation
// - termination control never affects decoding or clock-enable transitions
// - self refresh held while clock enable low; exits on rise with idle command
// - refresh with clock enable falling enters self refresh only from idle
// - clock enable falling with idle command enters active or precharge power-down
// - no internal refresh activity while in power-down
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_map.svh"
module sdcd_top #(
  parameter int BANKS     = `SDCD_BANKS,
  parameter int BURST_CYC = `SDCD_BURST_CYC
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     cs_n_in,
  input  wire logic                     ras_n_in,
  input  wire logic                     cas_n_in,
  input  wire logic                     we_n_in,
  input  wire logic                     cke_in,
  input  wire logic [`SDCD_BA_W-1:0]    ba_in,
  input  wire logic [`SDCD_ADDR_W-1:0]  addr_in,
  input  wire logic                     termination_ctrl_in,
  output logic [3:0]                    mode_register_set_out,
  output logic [`SDCD_ADDR_W-1:0]       mode_reg0_out,
  output logic [BANKS-1:0]              bank_open_out,
  output logic                          burst_busy_out,
  output logic                          burst_write_out,
  output logic [3:0]                    burst_beats_out,
  output logic                          burst_autoclose_out,
  output logic                          impedance_cal_long_out,
  output logic                          impedance_cal_short_out,
  output logic                          cal_initial_out,
  output logic                          refresh_out,
  output logic                          self_refresh_out,
  output logic                          active_power_down_out,
  output logic                          precharge_power_down_out,
  output logic                          illegal_cmd_out
);
  initial begin
    if (BANKS != `SDCD_BANKS) $error("BANKS must equal the bank address range");
    if (BURST_CYC < 1 || BURST_CYC > 15) $error("BURST_CYC out of range");
  end

  // two-flop synchronisers; first stage read only by the second
  localparam int PW = 5 + `SDCD_BA_W + `SDCD_ADDR_W;
  logic [PW-1:0] meta_q, sync_q;
  logic          cke_prev_q;
  // termination_ctrl_in is never sampled, so it cannot steer decoding
  // reset to deselect with clock enable high: a zero reset would fake an exit
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q     <= {5'h1F, {(PW-5){1'h0}}};
      sync_q     <= {5'h1F, {(PW-5){1'h0}}};
      cke_prev_q <= 1'h1;
    end else begin
      meta_q     <= {cs_n_in, ras_n_in, cas_n_in, we_n_in, cke_in, ba_in, addr_in};
      sync_q     <= meta_q;
      cke_prev_q <= sync_q[PW-5];
    end
  end

  logic [`SDCD_ADDR_W-1:0] addr_s;
  sdcd_pins_if pins ();
  assign addr_s        = sync_q[`SDCD_ADDR_W-1:0];
  assign pins.cs_n     = sync_q[PW-1];
  assign pins.ras_n    = sync_q[PW-2];
  assign pins.cas_n    = sync_q[PW-3];
  assign pins.we_n     = sync_q[PW-4];
  assign pins.cke      = sync_q[PW-5];
  assign pins.cke_prev = cke_prev_q;
  assign pins.ba       = sync_q[`SDCD_ADDR_W +: `SDCD_BA_W];
  assign pins.ap       = addr_s[`SDCD_AP_POS];
  assign pins.bc       = addr_s[`SDCD_BC_POS];

  sdcd_pkg::sdcd_cmd_t cmd;
  sdcd_decode u_dec (
    .pins    (pins),
    .cmd_out (cmd)
  );

  sdcd_pkg::sdcd_state_t st_q, st_d;
  logic [3:0]              mrs_q, mrs_d;
  logic [`SDCD_ADDR_W-1:0] mr0_q, mr0_d;
  logic [BANKS-1:0]        open_q, open_d;
  logic [3:0]              bcnt_q, bcnt_d;
  logic                    bwr_q, bwr_d, bap_q, bap_d;
  logic [3:0]              beats_q, beats_d;
  logic                    zql_q, zql_d, zqs_q, zqs_d, init_q, init_d, first_q, first_d;
  logic                    ref_q, ref_d, apd_q, apd_d, ppd_q, ppd_d, ill_q, ill_d;
  logic [2:0]              ba_s;
  logic                    idle, busy;
  logic                    busy_q, busy_d, sref_q, sref_d;

  always_comb begin
    ba_s    = pins.ba;
    busy    = (bcnt_q != 4'h0);
    idle    = (open_q == '0) && !busy;
    st_d    = st_q;
    mrs_d   = 4'h0;
    mr0_d   = mr0_q;
    open_d  = open_q;
    bcnt_d  = busy ? bcnt_q - 4'h1 : 4'h0;
    bwr_d   = bwr_q;
    bap_d   = bap_q;
    beats_d = beats_q;
    zql_d   = 1'b0;
    zqs_d   = 1'b0;
    init_d  = 1'b0;
    first_d = first_q;
    ref_d   = 1'b0;
    ill_d   = 1'b0;
    if (!busy && bap_q) begin
      bap_d = 1'b0;
    end
    case (st_q)
      sdcd_pkg::SDCD_ST_SREF: begin
        // held whatever the pins do until a clean rise
        if (cmd == sdcd_pkg::SDCD_CMD_PDX) st_d = sdcd_pkg::SDCD_ST_RUN;
      end
      sdcd_pkg::SDCD_ST_PDN: begin
        // no refresh of our own here: ref_d stays low
        if (cmd == sdcd_pkg::SDCD_CMD_PDX) st_d = sdcd_pkg::SDCD_ST_RUN;
      end
      default: begin
        case (cmd)
          sdcd_pkg::SDCD_CMD_MRS: begin
            mrs_d[ba_s[1:0]] = !ba_s[2];
            if (ba_s == 3'h0) mr0_d = addr_s;
            ill_d = ba_s[2];
          end
          sdcd_pkg::SDCD_CMD_REF:  ref_d = 1'b1;
          sdcd_pkg::SDCD_CMD_ACT:  open_d[ba_s] = 1'b1;
          sdcd_pkg::SDCD_CMD_PRE:  open_d[ba_s] = 1'b0;
          sdcd_pkg::SDCD_CMD_ALL_BANK_CLOSE: open_d = '0;
          sdcd_pkg::SDCD_CMD_WR, sdcd_pkg::SDCD_CMD_RD: begin
            if (busy || !open_q[ba_s]) begin
              ill_d = 1'b1;
            end else begin
              bcnt_d = BURST_CYC[3:0];
              bwr_d  = (cmd == sdcd_pkg::SDCD_CMD_WR);
              bap_d  = pins.ap;
              if (mr0_q[`SDCD_MR_OTF_POS])
                beats_d = pins.bc ? `SDCD_BEATS_EIGHT : `SDCD_BEATS_FOUR;
              else
                beats_d = mr0_q[`SDCD_MR_CHOP_POS] ? `SDCD_BEATS_FOUR : `SDCD_BEATS_EIGHT;
              if (pins.ap) open_d[ba_s] = 1'b0;
            end
          end
          sdcd_pkg::SDCD_CMD_ZQL: begin
            zql_d   = 1'b1;
            init_d  = first_q;
            first_d = 1'b0;
          end
          sdcd_pkg::SDCD_CMD_ZQS: zqs_d = 1'b1;
          sdcd_pkg::SDCD_CMD_SRE: begin
            if (idle) st_d = sdcd_pkg::SDCD_ST_SREF;
            else ill_d = 1'b1;
          end
          sdcd_pkg::SDCD_CMD_PDE: st_d = sdcd_pkg::SDCD_ST_PDN;
          sdcd_pkg::SDCD_CMD_NONE: ;
          default: ill_d = 1'b1;
        endcase
      end
    endcase
    apd_d = (st_d == sdcd_pkg::SDCD_ST_PDN) && (open_d != '0);
    ppd_d = (st_d == sdcd_pkg::SDCD_ST_PDN) && (open_d == '0);
    busy_d = (bcnt_d != 4'h0);
    sref_d = (st_d == sdcd_pkg::SDCD_ST_SREF);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= sdcd_pkg::SDCD_ST_RUN;
      mrs_q <= 4'h0;
      mr0_q <= '0;
      open_q <= '0;
      bcnt_q <= 4'h0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      beats_q <= `SDCD_BEATS_EIGHT;
      zql_q <= 1'b0;
      zqs_q <= 1'b0;
      init_q <= 1'b0;
      first_q <= 1'b1;
      ref_q <= 1'b0;
      apd_q <= 1'b0;
      ppd_q <= 1'b0;
      ill_q <= 1'b0;
      busy_q <= 1'b0;
      sref_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mrs_q <= mrs_d;
      mr0_q <= mr0_d;
      open_q <= open_d;
      bcnt_q <= bcnt_d;
      bwr_q <= bwr_d;
      bap_q <= bap_d;
      beats_q <= beats_d;
      zql_q <= zql_d;
      zqs_q <= zqs_d;
      init_q <= init_d;
      first_q <= first_d;
      ref_q <= ref_d;
      apd_q <= apd_d;
      ppd_q <= ppd_d;
      ill_q <= ill_d;
      busy_q <= busy_d;
      sref_q <= sref_d;
    end
  end

  always_comb begin
    mode_register_set_out    = mrs_q;
    mode_reg0_out            = mr0_q;
    bank_open_out            = open_q;
    burst_busy_out           = busy_q;
    burst_write_out          = bwr_q;
    burst_beats_out          = beats_q;
    burst_autoclose_out      = bap_q;
    impedance_cal_long_out   = zql_q;
    impedance_cal_short_out  = zqs_q;
    cal_initial_out          = init_q;
    refresh_out              = ref_q;
    self_refresh_out         = sref_q;
    active_power_down_out    = apd_q;
    precharge_power_down_out = ppd_q;
    illegal_cmd_out          = ill_q;
  end

  a_mrs_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd == sdcd_pkg::SDCD_CMD_MRS && st_q == sdcd_pkg::SDCD_ST_RUN && !pins.ba[2]
    |=> mrs_q != 4'h0) else $error("mode set not flagged");
  a_act_opens: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd == sdcd_pkg::SDCD_CMD_ACT && st_q == sdcd_pkg::SDCD_ST_RUN
    |=> open_q[$past(pins.ba)]) else $error("bank not opened");
  a_all_bank_close_closes: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd == sdcd_pkg::SDCD_CMD_ALL_BANK_CLOSE && st_q == sdcd_pkg::SDCD_ST_RUN
    |=> open_q == '0) else $error("banks not closed");
  a_burst_runs: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(burst_busy_out) |-> burst_busy_out [*4]) else $error("burst cut");
  a_cal_kind: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd == sdcd_pkg::SDCD_CMD_ZQL && st_q == sdcd_pkg::SDCD_ST_RUN
    |=> zql_q && !zqs_q) else $error("long cal missing");
  a_nop_still: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd == sdcd_pkg::SDCD_CMD_NONE && st_q == sdcd_pkg::SDCD_ST_RUN
    |=> open_q == $past(open_q) && !ill_q) else $error("nop changed state");
  a_sref_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_q == sdcd_pkg::SDCD_ST_SREF && !pins.cke |=> self_refresh_out)
    else $error("self refresh left");
  a_sre_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(self_refresh_out) |-> $past(idle)) else $error("self refresh not idle");
  a_pdn_norefr: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    st_q == sdcd_pkg::SDCD_ST_PDN |=> !refresh_out) else $error("refresh in power-down");
  c_write: cover property (@(posedge ref_clk_in) $rose(burst_busy_out) && burst_write_out);
  c_sref: cover property (@(posedge ref_clk_in) $fell(self_refresh_out));
  c_apd: cover property (@(posedge ref_clk_in) $rose(active_power_down_out));
endmodule
`default_nettype wire

// ==== sim/sdcd_ctrl_model.sv ====
/*
  memory controller model driving command, bank, address and clock-enable pins.
  assumes the bench calls send() by hierarchical name, one call at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
  input  wire logic        clk_in,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic             cke_out,
  output logic [2:0]       ba_out,
  output logic [15:0]      addr_out
);
  initial begin
    cs_n_out = 1'h1;
    cke_out = 1'h1;
    {ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} = 22'h0;
  end
  // released pins flip to the inverse so a stale command never looks valid
  task automatic send(input int gap, input logic [2:0] rcw, input logic [2:0] ba,
                      input logic [15:0] addr, input logic cke);
    repeat (gap) @(posedge clk_in);
    if (cke !== cke_out) begin
      repeat (3) @(posedge clk_in);
    end
    @(posedge clk_in);
    cs_n_out <= 1'h0;
    {ras_n_out, cas_n_out, we_n_out} <= rcw;
    ba_out <= ba;
    addr_out <= addr;
    cke_out <= cke;
    @(posedge clk_in);
    cs_n_out <= 1'h1;
    {ras_n_out, cas_n_out, we_n_out, ba_out, addr_out} <= ~{rcw, ba, addr};
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_sdram_command_decoder.sv ====
/*
  self-checking bench of the command decoder with a controller model.
  assumes a fixed two-cycle latency from pin sample to outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_sdram_command_decoder;
  localparam logic [2:0] MODE_REGISTER_SET = 3'h0, REF = 3'h1, PRE = 3'h2, ACT = 3'h3;
  localparam logic [2:0] WR = 3'h4, RD = 3'h5, ZQ = 3'h6, NO_OPERATION = 3'h7;
  logic        ref_clk_in, rst_n_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, cke_in;
  logic        termination_ctrl_in, bc;
  logic [2:0]  ba_in, b;
  logic [15:0] addr_in, mode_reg0_out, op;
  logic [3:0]  mode_register_set_out, burst_beats_out;
  logic [7:0]  bank_open_out;
  logic        burst_busy_out, burst_write_out, burst_autoclose_out, impedance_cal_long_out;
  logic        impedance_cal_short_out, cal_initial_out, refresh_out, self_refresh_out;
  logic        active_power_down_out, precharge_power_down_out, illegal_cmd_out;
  int          failures, checked;
  sdcd_top #(.BANKS(8), .BURST_CYC(4)) dut (
    .ref_clk_in, .rst_n_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .cke_in, .ba_in,
    .addr_in, .termination_ctrl_in, .mode_register_set_out, .mode_reg0_out, .bank_open_out,
    .burst_busy_out, .burst_write_out, .burst_beats_out, .burst_autoclose_out,
    .impedance_cal_long_out, .impedance_cal_short_out, .cal_initial_out, .refresh_out,
    .self_refresh_out, .active_power_down_out, .precharge_power_down_out, .illegal_cmd_out);
  sdcd_ctrl_model ctl (.clk_in(ref_clk_in), .cs_n_out(cs_n_in), .ras_n_out(ras_n_in),
    .cas_n_out(cas_n_in), .we_n_out(we_n_in), .cke_out(cke_in), .ba_out(ba_in),
    .addr_out(addr_in));
  initial begin
    ref_clk_in = 1'h0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) termination_ctrl_in <= 1'($urandom);
  function automatic logic [3:0] beats_for(input logic [15:0] mr, input logic chop);
    if (mr[0]) return chop ? 4'h8 : 4'h4;
    return mr[1] ? 4'h4 : 4'h8;
  endfunction
  function automatic logic [15:0] mk(input logic a10, input logic a12);
    logic [15:0] r;
    r = 16'($urandom);
    r[10] = a10;
    r[12] = a12;
    return r;
  endfunction
  // issue one command, then land on the cycle its outputs are valid
  task automatic go(input logic [2:0] rcw, input logic [2:0] bk, input logic [15:0] a,
                    input logic k);
    ctl.send($urandom_range(2), rcw, bk, a, k);
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(59));
    failures = 0;
    checked = 0;
    termination_ctrl_in = 1'h0;
    rst_n_in = 1'h0;
    repeat (20) @(posedge ref_clk_in);
    #1;
    `CHK("beats", 4'h8, burst_beats_out);
    `CHK("banks", 8'h0, bank_open_out);
    @(posedge ref_clk_in);
    rst_n_in <= 1'h1;
    repeat (4) @(posedge ref_clk_in);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      op = 16'($urandom);
      go(MODE_REGISTER_SET, 3'(i), op, 1'h1);
      `CHK("mrs", 4'h1 << i, mode_register_set_out);
    end
    go(MODE_REGISTER_SET, 3'h4, op, 1'h1);
    `CHK("mrs bad", 1'h1, illegal_cmd_out);
    op = 16'($urandom);
    go(MODE_REGISTER_SET, 3'h0, op, 1'h1);
    `CHK("mode0", op, mode_reg0_out);
    done("mode");
    b = 3'($urandom);
    bc = 1'($urandom);
    go(ACT, b, 16'($urandom), 1'h1);
    `CHK("open", 8'h1 << b, bank_open_out);
    ctl.send(0, RD, b, mk(1'h0, bc), 1'h1);
    ctl.send(0, RD, b, mk(1'h0, ~bc), 1'h1);
    @(posedge ref_clk_in);
    #1;
    `CHK("busy", 1'h1, burst_busy_out);
    `CHK("beats", beats_for(op, bc), burst_beats_out);
    `CHK("kind", 1'h0, burst_write_out);
    @(posedge ref_clk_in);
    #1;
    `CHK("refused", 1'h1, illegal_cmd_out);
    `CHK("beats", beats_for(op, bc), burst_beats_out);
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("busy", 1'h0, burst_busy_out);
    go(WR, b, mk(1'h1, ~bc), 1'h1);
    `CHK("kind", 1'h1, burst_write_out);
    `CHK("autoclose", 1'h1, burst_autoclose_out);
    `CHK("beats", beats_for(op, ~bc), burst_beats_out);
    repeat (4) @(posedge ref_clk_in);
    #1;
    `CHK("open", 8'h0, bank_open_out);
    done("burst");
    go(ACT, b, 16'($urandom), 1'h1);
    go(ACT, b ^ 3'h1, 16'($urandom), 1'h1);
    go(PRE, b, mk(1'h0, bc), 1'h1);
    `CHK("open", 8'h1 << (b ^ 3'h1), bank_open_out);
    go(ACT, b, 16'($urandom), 1'h1);
    go(PRE, ~b, mk(1'h1, bc), 1'h1);
    `CHK("open", 8'h0, bank_open_out);
    done("precharge");
    for (int i = 0; i < 3; i++) begin
      go(ZQ, 3'($urandom), mk(1'(i < 2), bc), 1'h1);
      `CHK("zq long", 1'(i < 2), impedance_cal_long_out);
      `CHK("zq short", 1'(i == 2), impedance_cal_short_out);
      `CHK("zq init", 1'(i == 0), cal_initial_out);
    end
    done("calibration");
    go(ACT, b, 16'($urandom), 1'h1);
    go(NO_OPERATION, ~b, mk(1'h1, 1'h1), 1'h1);
    `CHK("open", 8'h1 << b, bank_open_out);
    `CHK("illegal", 1'h0, illegal_cmd_out);
    go(NO_OPERATION, b, 16'($urandom), 1'h0);
    `CHK("act pd", 1'h1, active_power_down_out);
    `CHK("pre pd", 1'h0, precharge_power_down_out);
    go(REF, b, 16'($urandom), 1'h0);
    `CHK("refresh", 1'h0, refresh_out);
    `CHK("act pd", 1'h1, active_power_down_out);
    go(NO_OPERATION, b, 16'($urandom), 1'h1);
    `CHK("act pd", 1'h0, active_power_down_out);
    `CHK("open", 8'h1 << b, bank_open_out);
    go(PRE, b, mk(1'h1, bc), 1'h1);
    go(REF, b, 16'($urandom), 1'h1);
    `CHK("refresh", 1'h1, refresh_out);
    go(NO_OPERATION, b, 16'($urandom), 1'h0);
    `CHK("pre pd", 1'h1, precharge_power_down_out);
    go(NO_OPERATION, b, 16'($urandom), 1'h1);
    `CHK("pre pd", 1'h0, precharge_power_down_out);
    done("power down");
    go(REF, b, 16'($urandom), 1'h0);
    `CHK("self ref", 1'h1, self_refresh_out);
    for (int i = 0; i < 3; i++) begin
      go(3'($urandom), 3'($urandom), 16'($urandom), 1'h0);
      `CHK("self ref", 1'h1, self_refresh_out);
    end
    go(NO_OPERATION, b, 16'($urandom), 1'h1);
    `CHK("self ref", 1'h0, self_refresh_out);
    go(ACT, b, 16'($urandom), 1'h1);
    go(REF, b, 16'($urandom), 1'h0);
    `CHK("sre busy", 1'h1, illegal_cmd_out);
    `CHK("self ref", 1'h0, self_refresh_out);
    done("self refresh");
    close_out();
  end
endmodule
`default_nettype wire
